// ---- pss_defines.svh ----
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define PSS_IDX_CTRL    8'hc0
`define PSS_IDX_NMI     8'hc4
`define PSS_IDX_SLPSEL  8'hc8
`define PSS_IDX_SUSSEL  8'hc9
`define PSS_IDX_SLPTMR  8'hcd
`define PSS_IDX_SUSTMR  8'hce
`define PSS_IDX_RESUME  8'hda

// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define PSS_RST_SLPSEL  8'h0c
`define PSS_RST_SUSSEL  8'h00
`define PSS_RST_MASK    8'hff
`define PSS_PINS_ON     8'hff
`define PSS_OFF_PINS    8'h7b
`define PSS_MASK_EXT    1
`define PSS_MASK_SLEEP  4
`define PSS_MASK_SUSP   5
`define PSS_CTRL_OFF    7
`define PSS_WAKE_EXT    2'h1
`define PSS_WAKE_RTC    2'h2
`define PSS_WAKE_RING   2'h3
`define PSS_CAUSE_EXT   2'h1
`define PSS_CAUSE_SLEEP 2'h2
`define PSS_CAUSE_SUSP  2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSS_CLK_NS      20
`define PSS_STOP_NS     15000
`define PSS_STOP_CYC    (`PSS_STOP_NS / `PSS_CLK_NS)
`define PSS_SEC_NS      1000000000
`define PSS_SEC_CYC     (`PSS_SEC_NS / `PSS_CLK_NS)
`define PSS_XTAL_RST    16
`define PSS_XTAL_CLK    2

`endif

// ---- pss_pkg.sv ----
package pss_pkg;

  typedef enum logic [1:0] {
    PM_ON      = 2'b00,
    PM_DOZE    = 2'b01,
    PM_SLEEP   = 2'b10,
    PM_SUSPEND = 2'b11
  } pss_pm_e;

  typedef enum logic [3:0] {
    SQ_RUN   = 4'h0,
    SQ_DACK  = 4'h1,
    SQ_PGO   = 4'h2,
    SQ_BURST = 4'h3,
    SQ_CLAMP = 4'h4,
    SQ_DOWN  = 4'h5,
    SQ_PGW   = 4'h6,
    SQ_PGDLY = 4'h7,
    SQ_RSTH  = 4'h8,
    SQ_CLKH  = 4'h9
  } pss_seq_e;

  typedef struct packed {
    pss_pm_e     pm;
    pss_seq_e    sq;
    logic        off;
    logic [1:0]  wake;
    logic        resumed;
    logic [1:0]  cause;
    logic        nmi;
    logic [7:0]  mask;
    logic [7:0]  slp_sel;
    logic [7:0]  sus_sel;
    logic [7:0]  slp_tmr;
    logic [7:0]  sus_tmr;
    logic [2:0]  div;
    logic [31:0] tick;
    logic [7:0]  idle;
    logic [31:0] cnt;
    logic        sw_prev;
    logic        ri_prev;
    logic        dack_prev;
    logic        pgo_prev;
    logic        awrdy;
    logic        wrdy;
    logic        aok;
    logic [7:0]  aidx;
    logic [7:0]  wd;
    logic        wen;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic        cpu_en;
    logic [2:0]  cpu_div;
    logic [7:0]  pins;
    logic        sys_pwr;
    logic        bus_rst_n;
    logic        pad_float;
    logic        clamp;
    logic        rtc_ref;
    logic        owner;
    logic        osc_en;
    logic        cpu_rst;
  } pss_state_s;

endpackage : pss_pkg

// ---- pss_power_sequencer.sv ----
// Contract
// - SLEEP divides CPU clock; divider write enables switch NMI
// - Unmasked SLEEP timeout raises NMI instead
// - Reading NMI mask register clears pending NMI
// - SLEEP command enters SLEEP from ON/DOZE
// - Idle timeout with masked NMI enters SLEEP
// - SLEEP exits on activity or command
// - SLEEP entry drives pins from SLEEP select
// - SUSPEND entry drives pins from SUSPEND select
// - CPU clock stops within 15 us
// - Nonzero SUSPEND timer raises NMI after SLEEP time
// - Switch rising edge raises NMI when unmasked
// - Writing 03h enters SUSPEND from ON/DOZE/SLEEP
// - Resume sources return ON, source recorded
// - Resume from SUSPEND keeps CPU running
// - Reading resume bit clears it
// - OFF skips refresh; leaving OFF resets CPU
// - SUSPEND clamps buses low; OFF floats all
// - Take memory, RTC refresh, stop clock, reset
// - Drop system power, clamp one second later
// - Wake releases clamp, powers up, awaits good
// - One second, 16 then 2 cycles to ON
// - Low state bits report and force state
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pss_defines.svh"

module pss_power_sequencer #(
  parameter int TICK_CYCLES = `PSS_SEC_CYC,
  parameter int SEC_CYCLES  = `PSS_SEC_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        activity,
  input  wire logic        power_switch_input,
  input  wire logic        ring_indicate_input,
  input  wire logic        rtc_alarm,
  input  wire logic        refresh_acknowledge_n,
  input  wire logic        power_good_out_strobe,
  input  wire logic        burst_refresh_done,
  input  wire logic        supply_power_good,
  output logic             nmi,
  output logic             cpu_core_clock_enable,
  output logic [2:0]       cpu_core_clock_divider,
  output logic [7:0]       power_control_pins,
  output logic             system_power_enable,
  output logic             bus_reset_out_n,
  output logic             pads_float,
  output logic             bus_clamp_low,
  output logic             refresh_on_rtc_clock,
  output logic             pmu_refresh_owner,
  output logic             main_osc_enable,
  output logic             cpu_reset
);
  import pss_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic pss_mapped(input logic [7:0] i);
    pss_mapped = (i == `PSS_IDX_CTRL)   || (i == `PSS_IDX_NMI)    ||
                 (i == `PSS_IDX_SLPSEL) || (i == `PSS_IDX_SUSSEL) ||
                 (i == `PSS_IDX_SLPTMR) || (i == `PSS_IDX_SUSTMR) ||
                 (i == `PSS_IDX_RESUME);
  endfunction : pss_mapped

  function automatic logic pss_addr_ok(input logic [11:0] a);
    pss_addr_ok = (a[11:10] == 2'b00) && pss_mapped(a[9:2]);
  endfunction : pss_addr_ok

  localparam logic [31:0] STOP_LIM = 32'(`PSS_STOP_CYC - 1);
  localparam logic [31:0] SEC_LIM  = 32'(SEC_CYCLES - 1);
  localparam logic [31:0] TICK_LIM = 32'(TICK_CYCLES - 1);

  pss_state_s q;
  pss_state_s d;

  logic       sw_rise;
  logic       ri_rise;
  logic       do_wr;
  logic       tick;
  logic [7:0] ridx;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    d       = q;
    sw_rise = power_switch_input && !q.sw_prev;
    ri_rise = ring_indicate_input && !q.ri_prev;
    tick    = (q.tick == TICK_LIM);
    ridx    = s_axi_araddr[9:2];
    do_wr   = !q.awrdy && !q.wrdy && !q.bvalid;
    d.sw_prev   = power_switch_input;
    d.ri_prev   = ring_indicate_input;
    d.dack_prev = refresh_acknowledge_n;
    d.pgo_prev  = power_good_out_strobe;
    d.tick      = tick ? 32'h0 : q.tick + 32'h1;
    d.cnt       = q.cnt + 32'h1;

    // Write channels are taken independently; answer after both
    if (s_axi_awvalid && q.awrdy) begin
      d.awrdy = 1'b0;
      d.aidx  = s_axi_awaddr[9:2];
      d.aok   = pss_addr_ok(s_axi_awaddr);
    end
    if (s_axi_wvalid && q.wrdy) begin
      d.wrdy = 1'b0;
      d.wd   = s_axi_wdata[7:0];
      d.wen  = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.awrdy  = 1'b1;
      d.wrdy   = 1'b1;
    end
    if (do_wr) begin
      d.bvalid = 1'b1;
      d.bresp  = q.aok ? 2'b00 : 2'b11;
      if (q.aok && q.wen) begin
        case (q.aidx)
          `PSS_IDX_CTRL: begin
            if (q.sq == SQ_RUN) begin
              if (q.wd[1:0] == PM_SUSPEND) begin
                d.sq  = q.wd[`PSS_CTRL_OFF] ? SQ_PGO : SQ_DACK;
                d.off = q.wd[`PSS_CTRL_OFF];
                d.cnt = 32'h0;
              end else begin
                d.pm   = pss_pm_e'(q.wd[1:0]);
                d.idle = 8'h00;
              end
            end
          end
          `PSS_IDX_NMI:    d.mask    = q.wd;
          `PSS_IDX_SLPSEL: d.slp_sel = q.wd;
          `PSS_IDX_SUSSEL: d.sus_sel = q.wd;
          `PSS_IDX_SLPTMR: d.slp_tmr = q.wd;
          `PSS_IDX_SUSTMR: d.sus_tmr = q.wd;
          `PSS_IDX_RESUME: begin
            // divider write also unmasks switch NMI
            d.div                  = q.wd[2:0];
            d.mask[`PSS_MASK_EXT] = 1'b0;
          end
          default: d.div = q.div;
        endcase
      end
    end

    // Reads answer one cycle after the address is taken
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arrdy  = 1'b1;
    end
    if (s_axi_arvalid && q.arrdy) begin
      d.arrdy  = 1'b0;
      d.rvalid = 1'b1;
      d.rresp  = pss_addr_ok(s_axi_araddr) ? 2'b00 : 2'b11;
      d.rdata  = 8'h00;
      if (s_axi_araddr[11:10] == 2'b00) begin
        case (ridx)
          `PSS_IDX_CTRL: begin
            d.rdata   = {q.cause, 1'b0, q.resumed, q.wake, q.pm};
            d.resumed = 1'b0;
          end
          `PSS_IDX_NMI: begin
            d.rdata = {q.cause, q.mask[5:0]};
            d.nmi   = 1'b0;
            d.cause = 2'h0;
          end
          `PSS_IDX_SLPSEL: d.rdata = q.slp_sel;
          `PSS_IDX_SUSSEL: d.rdata = q.sus_sel;
          `PSS_IDX_SLPTMR: d.rdata = q.slp_tmr;
          `PSS_IDX_SUSTMR: d.rdata = q.sus_tmr;
          `PSS_IDX_RESUME: d.rdata = {q.owner, 4'h0, q.div};
          default:         d.rdata = 8'h00;
        endcase
      end
    end

    // Activity timers and NMI sources run only in SQ_RUN, SLEEP included
    if (q.sq == SQ_RUN) begin
      if (activity) begin
        d.idle = 8'h00;
        if (q.pm == PM_SLEEP) d.pm = PM_ON;
      end else if (tick && q.idle != 8'hff) begin
        d.idle = q.idle + 8'h01;
      end
      if (!activity && tick && q.pm != PM_SLEEP && q.slp_tmr != 8'h00 &&
          q.idle + 8'h01 == q.slp_tmr) begin
        if (q.mask[`PSS_MASK_SLEEP]) begin
          d.pm   = PM_SLEEP;
          d.idle = 8'h00;
        end else begin
          d.nmi   = 1'b1;
          d.cause = `PSS_CAUSE_SLEEP;
        end
      end
      // time spent in SLEEP against SUSPEND timer
      if (!activity && tick && q.pm == PM_SLEEP && q.sus_tmr != 8'h00 &&
          q.idle + 8'h01 == q.sus_tmr && !q.mask[`PSS_MASK_SUSP]) begin
        d.nmi   = 1'b1;
        d.cause = `PSS_CAUSE_SUSP;
      end
      if (sw_rise && !q.mask[`PSS_MASK_EXT]) begin
        d.nmi   = 1'b1;
        d.cause = `PSS_CAUSE_EXT;
      end
      // slowed clock in DOZE and SLEEP
      d.cpu_div = (d.pm == PM_ON) ? 3'h0 : q.div;
      d.pins    = (d.pm == PM_SLEEP) ? q.slp_sel : `PSS_PINS_ON;
    end

    // Suspend and resume sequencing
    case (q.sq)
      // Left alone so a suspend command taken above is not undone
      SQ_RUN: ;
      SQ_DACK: begin
        // take memory on refresh acknowledge rise
        if (refresh_acknowledge_n && !q.dack_prev) begin
          d.owner   = 1'b1;
          d.rtc_ref = 1'b1;
          d.sq      = SQ_PGO;
        end
      end
      SQ_PGO: begin
        // clock stops at strobe fall or the limit
        if ((!power_good_out_strobe && q.pgo_prev) || q.cnt >= STOP_LIM) begin
          d.cpu_en    = 1'b0;
          d.bus_rst_n = 1'b0;
          d.pad_float = 1'b1;
          d.pm        = PM_SUSPEND;
          d.pins      = q.sus_sel;
          if (q.off) begin
            // no refresh, power and RAM dropped
            d.sys_pwr = 1'b0;
            d.pins    = q.sus_sel & `PSS_OFF_PINS;
            d.cpu_rst = 1'b1;
            d.osc_en  = 1'b0;
            d.owner   = 1'b0;
            d.rtc_ref = 1'b0;
            d.sq      = SQ_DOWN;
          end else begin
            d.sq = SQ_BURST;
          end
        end
      end
      SQ_BURST: begin
        // power off once burst refresh ends
        if (burst_refresh_done) begin
          d.sys_pwr = 1'b0;
          d.cnt     = 32'h0;
          d.sq      = SQ_CLAMP;
        end
      end
      SQ_CLAMP: begin
        // clamp buses low a second later
        if (q.cnt == SEC_LIM) begin
          d.clamp  = 1'b1;
          d.osc_en = 1'b0;
          d.sq     = SQ_DOWN;
        end
      end
      SQ_DOWN: d.sq = SQ_DOWN;
      SQ_PGW: begin
        if (supply_power_good) begin
          d.cnt = 32'h0;
          d.sq  = SQ_PGDLY;
        end
      end
      SQ_PGDLY: begin
        // pads return a second after good
        if (q.cnt == SEC_LIM) begin
          d.pad_float = 1'b0;
          d.cnt       = 32'h0;
          d.sq        = SQ_RSTH;
        end
      end
      SQ_RSTH: begin
        // bus reset lifts after 16 cycles
        if (q.cnt == 32'(`PSS_XTAL_RST - 1)) begin
          d.bus_rst_n = 1'b1;
          d.cpu_rst   = 1'b0;
          d.cnt       = 32'h0;
          d.sq        = SQ_CLKH;
        end
      end
      SQ_CLKH: begin
        // CPU clock returns two cycles later
        if (q.cnt == 32'(`PSS_XTAL_CLK - 1)) begin
          d.cpu_en  = 1'b1;
          d.cpu_div = 3'h0;
          d.pm      = PM_ON;
          d.pins    = `PSS_PINS_ON;
          d.owner   = 1'b0;
          d.rtc_ref = 1'b0;
          d.off     = 1'b0;
          d.idle    = 8'h00;
          d.sq      = SQ_RUN;
        end
      end
      default: d.sq = SQ_RUN;
    endcase

    // any resume source wakes; source recorded
    if ((q.sq == SQ_CLAMP || q.sq == SQ_DOWN) &&
        (sw_rise || ri_rise || rtc_alarm)) begin
      d.wake    = sw_rise ? `PSS_WAKE_EXT :
                  rtc_alarm ? `PSS_WAKE_RTC : `PSS_WAKE_RING;
      // clamp released, power and oscillator on
      d.clamp   = 1'b0;
      d.sys_pwr = 1'b1;
      d.osc_en  = 1'b1;
      d.pins    = `PSS_PINS_ON;
      // CPU reset only when leaving OFF
      d.resumed = !q.off;
      d.sq      = SQ_PGW;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q           <= '0;
      q.pm        <= PM_ON;
      q.sq        <= SQ_RUN;
      q.mask      <= `PSS_RST_MASK;
      q.slp_sel   <= `PSS_RST_SLPSEL;
      q.sus_sel   <= `PSS_RST_SUSSEL;
      q.awrdy     <= 1'b1;
      q.wrdy      <= 1'b1;
      q.arrdy     <= 1'b1;
      q.cpu_en    <= 1'b1;
      q.pins      <= `PSS_PINS_ON;
      q.sys_pwr   <= 1'b1;
      q.bus_rst_n <= 1'b1;
      q.osc_en    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Every output is a field of the state register
  assign s_axi_awready          = q.awrdy;
  assign s_axi_wready           = q.wrdy;
  assign s_axi_bvalid           = q.bvalid;
  assign s_axi_bresp            = q.bresp;
  assign s_axi_arready          = q.arrdy;
  assign s_axi_rvalid           = q.rvalid;
  assign s_axi_rresp            = q.rresp;
  assign s_axi_rdata            = {24'h0, q.rdata};
  assign nmi                    = q.nmi;
  assign cpu_core_clock_enable  = q.cpu_en;
  assign cpu_core_clock_divider = q.cpu_div;
  assign power_control_pins     = q.pins;
  assign system_power_enable    = q.sys_pwr;
  assign bus_reset_out_n        = q.bus_rst_n;
  assign pads_float             = q.pad_float;
  assign bus_clamp_low          = q.clamp;
  assign refresh_on_rtc_clock   = q.rtc_ref;
  assign pmu_refresh_owner      = q.owner;
  assign main_osc_enable        = q.osc_en;
  assign cpu_reset              = q.cpu_rst;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  nmi_read_clear_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && q.arrdy && s_axi_araddr == 12'h310 && !tick && !sw_rise)
    |=> !nmi) else $error("NMI not cleared by read");

  sleep_divider_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (q.sq == SQ_RUN && q.pm == PM_SLEEP && $stable(q.pm))
    |-> cpu_core_clock_divider == q.div) else $error("SLEEP divider wrong");

  sleep_pins_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (q.sq == SQ_RUN && q.pm == PM_SLEEP && $stable(q.pm))
    |-> power_control_pins == q.slp_sel) else $error("SLEEP pins wrong");

  stop_bound_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (q.sq == SQ_DACK || q.sq == SQ_PGO) |-> q.cnt <= STOP_LIM)
    else $error("CPU clock stop too late");

  off_float_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (q.off && q.sq == SQ_DOWN) |-> (!bus_clamp_low && pads_float))
    else $error("OFF buses not floating");

  clock_gap_a : assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bus_reset_out_n) |-> !cpu_core_clock_enable ##2 cpu_core_clock_enable)
    else $error("CPU clock not two cycles after reset");

  wake_up_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (q.sq == SQ_DOWN && rtc_alarm && !sw_rise) |=> (system_power_enable && !bus_clamp_low
    && q.wake == `PSS_WAKE_RTC)) else $error("Wake did not power up");

  ext_nmi_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (q.sq == SQ_RUN && power_switch_input && !q.sw_prev && !q.mask[1])
    |=> nmi) else $error("Switch NMI missing");

  clamp_power_a : assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bus_clamp_low) |-> !system_power_enable && q.owner)
    else $error("Clamp with power on");

  resume_keep_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (q.sq == SQ_BURST) |-> !cpu_reset) else $error("CPU reset on SUSPEND");

endmodule : pss_power_sequencer

// ---- pss_supply_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------
// Supply and memory side of the sequencer
// ----------------------------------------
module pss_supply_model #(
  parameter int PG_DLY = 5
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic system_power_enable,
  input  wire logic pmu_refresh_owner,
  input  wire logic pads_float,
  input  wire logic slow_pgo,
  output logic      refresh_acknowledge_n,
  output logic      power_good_out_strobe,
  output logic      burst_refresh_done,
  output logic      supply_power_good
);
  logic [3:0] ref_q;
  logic [3:0] pg_q;
  logic [2:0] own_q;

  // Refresh ack pulses low one cycle in sixteen, as the refresh timer would
  // memory handoff edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_q                 <= 4'h0;
      pg_q                  <= 4'h0;
      own_q                 <= 3'h0;
      refresh_acknowledge_n <= 1'b1;
      power_good_out_strobe <= 1'b1;
      burst_refresh_done    <= 1'b0;
      supply_power_good     <= 1'b0;
    end else begin
      ref_q                 <= ref_q + 4'h1;
      refresh_acknowledge_n <= (ref_q != 4'h0);
      own_q                 <= {own_q[1:0], pmu_refresh_owner};
      // A slow supply never drops its strobe; the sequencer must fall back
      power_good_out_strobe <= !(own_q[2] && !slow_pgo);
      burst_refresh_done    <= pads_float && own_q[2];
      pg_q                  <= !system_power_enable ? 4'h0 : (pg_q == 4'hf) ? pg_q : pg_q + 4'h1;
      supply_power_good     <= system_power_enable && (int'(pg_q) >= PG_DLY);
    end
  end
endmodule : pss_supply_model

// ---- test_power_state_sequencer.sv ----
`timescale 1ns/1ps
`include "pss_defines.svh"

module test_power_state_sequencer;
  import pss_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, act = 0, sw = 0, ring = 0, rtc = 0, slow = 0;
  logic dack_n, pgo, brd, spg, nmi, cpu_en, owner, sys_pwr, rst_n, flt, clamp, rtc_ref, cpu_rst;
  logic [2:0] div;
  logic [7:0] pins, s, dv, c8;
  int errors = 0, n_checks = 0, n, i, src;
  logic off, osc;

  initial forever #10 aclk = ~aclk;

  pss_power_sequencer #(.TICK_CYCLES(4), .SEC_CYCLES(8)) i_pss_power_sequencer (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .activity(act), .power_switch_input(sw), .ring_indicate_input(ring), .rtc_alarm(rtc),
    .refresh_acknowledge_n(dack_n), .power_good_out_strobe(pgo), .burst_refresh_done(brd),
    .supply_power_good(spg), .nmi(nmi), .cpu_core_clock_enable(cpu_en),
    .cpu_core_clock_divider(div), .power_control_pins(pins), .system_power_enable(sys_pwr),
    .bus_reset_out_n(rst_n), .pads_float(flt), .bus_clamp_low(clamp),
    .refresh_on_rtc_clock(rtc_ref), .pmu_refresh_owner(owner), .main_osc_enable(osc),
    .cpu_reset(cpu_rst));

  pss_supply_model i_pss_supply_model (
    .aclk(aclk), .aresetn(aresetn), .system_power_enable(sys_pwr), .pmu_refresh_owner(owner),
    .pads_float(flt), .slow_pgo(slow), .refresh_acknowledge_n(dack_n),
    .power_good_out_strobe(pgo), .burst_refresh_done(brd), .supply_power_good(spg));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait on one design output; the cycle count is handed back
  function automatic logic sig(input int k);
    case (k)
      0: return nmi;
      1: return cpu_en;
      2: return clamp;
      3: return flt;
      default: return rst_n;
    endcase
  endfunction : sig

  task wt(input int k, input logic v, output int cyc);
    cyc = 0;
    while (sig(k) !== v && cyc < 3000) begin
      @(posedge aclk);
      cyc++;
    end
    if (sig(k) !== v) begin
      errors++;
      final_report();
    end
  endtask : wt

  task wr(input logic [7:0] idx, input logic [7:0] v);
    int k;
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (k == 100) begin
      errors++;
      final_report();
    end
  endtask : wr

  task rd(input logic [7:0] idx, output logic [31:0] dat, output logic [1:0] rsp);
    int k;
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    dat = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (k == 100) begin
      errors++;
      final_report();
    end
  endtask : rd

  // Software polls the state bits, as a handler would
  task poll(input logic [1:0] st);
    for (int k = 0; k < 50; k++) begin
      rd(`PSS_IDX_CTRL, d, r);
      if (d[1:0] === st) break;
    end
  endtask : poll

  function automatic logic [7:0] exp_pins(input logic [7:0] sel, input logic is_off);
    return is_off ? (sel & `PSS_OFF_PINS) : sel;
  endfunction : exp_pins

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h99090dff));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, then an unmapped read
    rd(`PSS_IDX_CTRL, d, r); check(d, 32'h00);
    rd(`PSS_IDX_NMI, d, r); check(d, 32'h3f);
    rd(`PSS_IDX_SLPSEL, d, r); check(d, 32'h0c);
    rd(`PSS_IDX_SUSSEL, d, r); check(d, 32'h00);
    rd(8'hff, d, r); check({r, d[29:0]}, {2'b11, 30'h0});
    c8 = 8'($urandom);
    dv = 8'($urandom % 8);
    wr(`PSS_IDX_SLPSEL, c8);
    wr(`PSS_IDX_RESUME, dv);
    rd(`PSS_IDX_NMI, d, r); check(d, 32'h3d);
    rd(`PSS_IDX_RESUME, d, r); check(d[2:0], dv[2:0]);
    // Switch edge raises the NMI; reading the mask register clears it
    @(posedge aclk) sw <= 1'b1;
    wt(0, 1'b1, n);
    rd(`PSS_IDX_NMI, d, r); check(d, {24'h0, `PSS_CAUSE_EXT, 6'h3d});
    @(posedge aclk) sw <= 1'b0;
    check(nmi, 1'b0);
    // Commanded SLEEP, then activity brings it back
    wr(`PSS_IDX_CTRL, 8'h02);
    repeat (3) @(posedge aclk);
    rd(`PSS_IDX_CTRL, d, r); check(d[1:0], PM_SLEEP);
    check(div, dv[2:0]);
    check(pins, c8);
    @(posedge aclk) act <= 1'b1;
    @(posedge aclk) act <= 1'b0;
    poll(PM_ON); check(d[1:0], PM_ON);
    // Unmasked sleep timeout gives an NMI and stays awake
    wr(`PSS_IDX_NMI, 8'hed);
    wr(`PSS_IDX_SLPTMR, 8'h01);
    // Idle count only matches a one-tick timer just after activity
    @(posedge aclk) act <= 1'b1;
    @(posedge aclk) act <= 1'b0;
    wt(0, 1'b1, n);
    rd(`PSS_IDX_CTRL, d, r); check(d, {24'h0, `PSS_CAUSE_SLEEP, 4'h0, PM_ON});
    rd(`PSS_IDX_NMI, d, r); check(d, {24'h0, `PSS_CAUSE_SLEEP, 6'h2d});
    // Masked timeout sleeps on its own; then the suspend timer fires
    wr(`PSS_IDX_NMI, 8'hdd);
    wr(`PSS_IDX_SUSTMR, 8'h01);
    @(posedge aclk) act <= 1'b1;
    @(posedge aclk) act <= 1'b0;
    poll(PM_SLEEP); check(d[1:0], PM_SLEEP);
    wt(0, 1'b1, n);
    rd(`PSS_IDX_NMI, d, r); check(d, {24'h0, `PSS_CAUSE_SUSP, 6'h1d});
    wr(`PSS_IDX_SUSTMR, 8'h00);
    wr(`PSS_IDX_SLPTMR, 8'h00);
    // Three suspend rounds, one per wake source, then one OFF round
    for (i = 0; i < 4; i++) begin
      off = (i == 3);
      src = off ? int'($urandom % 3) : i;
      s = 8'($urandom);
      slow <= 1'($urandom);
      wr(`PSS_IDX_SUSSEL, s);
      wr(`PSS_IDX_CTRL, off ? 8'h83 : 8'h03);
      wt(1, 1'b0, n);
      check(n <= `PSS_STOP_CYC, 1'b1);
      // OFF never clamps, so the stop of the clock marks its end
      wt(2, !off, n);
      check(pins, exp_pins(s, off));
      check({flt, clamp, rst_n, sys_pwr, osc}, {1'b1, !off, 3'b000});
      check(rtc_ref, !off);
      check(cpu_rst, off);
      @(posedge aclk);
      sw <= (src == 0);
      rtc <= (src == 1);
      ring <= (src == 2);
      repeat (2) @(posedge aclk);
      check({clamp, sys_pwr, osc}, 3'b011);
      wt(3, 1'b0, n);
      wt(4, 1'b1, n);
      check(n, `PSS_XTAL_RST);
      wt(1, 1'b1, n);
      check(n, `PSS_XTAL_CLK);
      check(cpu_rst, 1'b0);
      {sw, rtc, ring} <= 3'b000;
      poll(PM_ON);
      check(d & 32'h1f, {27'h0, !off, 2'(src + 1), PM_ON});
      rd(`PSS_IDX_CTRL, d, r); check(d[4], 1'b0);
      rd(`PSS_IDX_RESUME, d, r); check(d[7], 1'b0);
      rd(`PSS_IDX_NMI, d, r);
    end
    final_report();
  end
endmodule : test_power_state_sequencer
